// [rtl/hart_flags.sv]
// per-hart set/clear flag array, clear wins on collision
`timescale 1ns/1ps
module hart_flags #(
	parameter int NUM_HARTS = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic active,
	input wire logic [NUM_HARTS-1:0] set_vec,
	input wire logic [NUM_HARTS-1:0] clr_vec,
	output logic [NUM_HARTS-1:0] flags_r
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= '0;
		end else if (!active) begin
			flags_r <= '0;
		end else begin
			flags_r <= (flags_r | set_vec) & ~clr_vec;
		end
	end
endmodule : hart_flags

// [rtl/hart_select.sv]
// selected-hart vector from index and mode
`timescale 1ns/1ps
module hart_select import module_control_pkg::*; #(
	parameter int NUM_HARTS = 4,
	parameter int INDEX_W = 2
) (
	input wire logic [INDEX_W-1:0] hart_index,
	input wire logic multi_sel,
	input wire logic [NUM_HARTS-1:0] array_mask,
	output logic [NUM_HARTS-1:0] selected
);
	always_comb begin
		for (int i = 0; i < NUM_HARTS; i++) begin
			selected[i] = ((INDEX_W)'(i) == hart_index) || (multi_sel && array_mask[i]);
		end
	end
endmodule : hart_select

// [rtl/module_control.sv]
// debug module control register with per-hart request outputs
`timescale 1ns/1ps
module module_control import module_control_pkg::*; #(
	parameter int NUM_HARTS = 4,
	parameter int INDEX_W = 2,
	parameter bit HAS_RESET_HALT = 1'b1,
	parameter bit HAS_HART_RESET = 1'b1,
	parameter bit HAS_ARRAY_MASK = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_HARTS-1:0] array_mask,
	input wire logic [NUM_HARTS-1:0] hart_halted,
	input wire logic [NUM_HARTS-1:0] hart_available,
	input wire logic [NUM_HARTS-1:0] hart_resume_done,
	input wire logic [NUM_HARTS-1:0] hart_was_reset,
	input wire logic [NUM_HARTS-1:0] hart_went_unavail,
	output logic [NUM_HARTS-1:0] halt_req_r,
	output logic [NUM_HARTS-1:0] resume_pulse_r,
	output logic [NUM_HARTS-1:0] hart_reset_r,
	output logic [NUM_HARTS-1:0] reset_halt_req_r,
	output logic [NUM_HARTS-1:0] keep_alive_r,
	output logic platform_reset_r,
	output logic active_r
);
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic wr_en;
	logic rd_en;
	logic ctl_wr;
	logic mapped;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign ctl_wr = wr_en && (paddr == MODULE_CONTROL_OFFSET) && active_r;
	assign mapped = (paddr == MODULE_CONTROL_OFFSET) || (paddr == SELECTED_STATUS_OFFSET)
		|| (paddr == CAPS_OFFSET);

	// ----------------------------------------
	// activation
	// ----------------------------------------
	logic active_req_r;
	logic [1:0] act_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_req_r <= 1'b0;
		end else if (wr_en && paddr == MODULE_CONTROL_OFFSET) begin
			active_req_r <= pwdata[ACTIVE_BIT];
		end
	end
	// shown only after a short settle, debugger must poll
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_cnt_r <= '0;
			active_r <= 1'b0;
		end else if (active_req_r == active_r) begin
			act_cnt_r <= '0;
		end else if (act_cnt_r == 2'(ACTIVATE_DELAY_CYCLES - 1)) begin
			act_cnt_r <= '0;
			active_r <= active_req_r;
		end else begin
			act_cnt_r <= act_cnt_r + 2'h1;
		end
	end

	// ----------------------------------------
	// held fields
	// ----------------------------------------
	logic [INDEX_W-1:0] hart_index_r;
	logic multi_sel_r;
	logic [MAX_INDEX_W-1:0] wr_index;
	logic [INDEX_W-1:0] new_index;
	logic new_multi;
	// unimplemented index bits drop so all-ones reads back the width
	assign wr_index = {pwdata[HART_SEL_HI_LSB +: HART_SEL_FIELD_W],
		pwdata[HART_SEL_LO_LSB +: HART_SEL_FIELD_W]};
	assign new_index = ctl_wr ? wr_index[INDEX_W-1:0] : hart_index_r;
	assign new_multi = ctl_wr ? (HAS_ARRAY_MASK && pwdata[MULTI_SEL_BIT]) : multi_sel_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hart_index_r <= '0;
			multi_sel_r <= 1'b0;
			platform_reset_r <= 1'b0;
		end else if (!active_r) begin
			hart_index_r <= '0;
			multi_sel_r <= 1'b0;
			platform_reset_r <= 1'b0;
		end else if (ctl_wr) begin
			hart_index_r <= new_index;
			multi_sel_r <= new_multi;
			platform_reset_r <= pwdata[PLATFORM_RESET_BIT];
		end
	end

	// ----------------------------------------
	// selection, from this write's values and from the held fields
	// ----------------------------------------
	logic [NUM_HARTS-1:0] sel_new;
	logic [NUM_HARTS-1:0] sel_cur;
	hart_select #(.NUM_HARTS(NUM_HARTS), .INDEX_W(INDEX_W)) u_sel_new (
		.hart_index(new_index),
		.multi_sel(new_multi),
		.array_mask(array_mask),
		.selected(sel_new)
	);
	hart_select #(.NUM_HARTS(NUM_HARTS), .INDEX_W(INDEX_W)) u_sel_cur (
		.hart_index(hart_index_r),
		.multi_sel(multi_sel_r),
		.array_mask(array_mask),
		.selected(sel_cur)
	);

	// ----------------------------------------
	// per-hart requests
	// ----------------------------------------
	logic [NUM_HARTS-1:0] wr_sel;
	logic resume_ok;
	assign wr_sel = ctl_wr ? sel_new : '0;
	assign resume_ok = pwdata[RESUME_BIT] && !pwdata[HALT_REQ_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_req_r <= '0;
		end else if (!active_r) begin
			halt_req_r <= '0;
		end else if (ctl_wr) begin
			halt_req_r <= pwdata[HALT_REQ_BIT] ? (halt_req_r | sel_new)
				: (halt_req_r & ~sel_new);
		end
	end

	// one pulse per write, so each halted hart resumes once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_pulse_r <= '0;
		end else begin
			resume_pulse_r <= resume_ok ? (wr_sel & hart_halted) : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hart_reset_r <= '0;
		end else if (!active_r || !HAS_HART_RESET) begin
			hart_reset_r <= '0;
		end else if (ctl_wr) begin
			hart_reset_r <= pwdata[HART_RESET_BIT] ? sel_new : '0;
		end
	end

	// halt-on-reset: hart acts on it at its reset release
	hart_flags #(.NUM_HARTS(NUM_HARTS)) u_reset_halt (
		.pclk(pclk),
		.presetn(presetn),
		.active(active_r),
		.set_vec(HAS_RESET_HALT && pwdata[SET_RESET_HALT_BIT] ? wr_sel : '0),
		.clr_vec(pwdata[CLR_RESET_HALT_BIT] ? wr_sel : '0),
		.flags_r(reset_halt_req_r)
	);

	// advisory only, the hart may still drop off
	hart_flags #(.NUM_HARTS(NUM_HARTS)) u_keep_alive (
		.pclk(pclk),
		.presetn(presetn),
		.active(active_r),
		.set_vec(pwdata[SET_KEEP_ALIVE_BIT] ? wr_sel : '0),
		.clr_vec(pwdata[CLR_KEEP_ALIVE_BIT] ? wr_sel : '0),
		.flags_r(keep_alive_r)
	);

	// ----------------------------------------
	// per-hart status flags, hardware set wins
	// ----------------------------------------
	logic [NUM_HARTS-1:0] resume_ack_r;
	logic [NUM_HARTS-1:0] have_reset_r;
	logic [NUM_HARTS-1:0] unavail_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_ack_r <= '0;
			have_reset_r <= '0;
			unavail_r <= '0;
		end else if (!active_r) begin
			resume_ack_r <= '0;
			have_reset_r <= '0;
			unavail_r <= '0;
		end else begin
			resume_ack_r <= (resume_ack_r & ~(resume_ok ? wr_sel : '0)) | hart_resume_done;
			have_reset_r <= (have_reset_r & ~(pwdata[ACK_RESET_BIT] ? wr_sel : '0))
				| hart_was_reset;
			unavail_r <= (unavail_r
				& ~(pwdata[ACK_UNAVAIL_BIT] ? (wr_sel & hart_available) : '0))
				| hart_went_unavail;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [31:0] ctl_view;
	logic [31:0] stat_view;
	logic [31:0] caps_view;
	logic [MAX_INDEX_W-1:0] idx_wide;
	logic all_resumed;
	assign idx_wide = MAX_INDEX_W'(hart_index_r);
	assign all_resumed = &(resume_ack_r | ~sel_cur);
	always_comb begin
		ctl_view = '0;
		ctl_view[ACTIVE_BIT] = active_r;
		ctl_view[PLATFORM_RESET_BIT] = platform_reset_r;
		ctl_view[HART_SEL_HI_LSB +: HART_SEL_FIELD_W] = idx_wide[MAX_INDEX_W-1 -: HART_SEL_FIELD_W];
		ctl_view[HART_SEL_LO_LSB +: HART_SEL_FIELD_W] = idx_wide[HART_SEL_FIELD_W-1:0];
		ctl_view[MULTI_SEL_BIT] = multi_sel_r;
		ctl_view[HART_RESET_BIT] = |(hart_reset_r & sel_cur);
		ctl_view[HALT_REQ_BIT] = 1'b0;
	end
	always_comb begin
		stat_view = '0;
		stat_view[3:0] = (active_r && !platform_reset_r) ? VERSION_VALUE : 4'h0;
		stat_view[4] = all_resumed;
		stat_view[5] = |(resume_ack_r & sel_cur);
		stat_view[6] = |(have_reset_r & sel_cur);
		stat_view[7] = |(unavail_r & sel_cur);
		stat_view[8] = |(hart_halted & sel_cur);
	end
	always_comb begin
		caps_view = '0;
		caps_view[0] = HAS_RESET_HALT;
		caps_view[1] = HAS_HART_RESET;
		caps_view[2] = HAS_ARRAY_MASK;
		caps_view[12:8] = 5'(INDEX_W);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				MODULE_CONTROL_OFFSET: prdata <= ctl_view;
				SELECTED_STATUS_OFFSET: prdata <= stat_view;
				CAPS_OFFSET: prdata <= caps_view;
				default: prdata <= '0;
			endcase
		end
	end

	// one wait-free access phase; unmapped address errors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
		end
	end
	logic unused_rd;
	assign unused_rd = rd_en;
endmodule : module_control

// [rtl/module_control_pkg.sv]
// constants for the debug module control register block
package module_control_pkg;
	localparam logic [11:0] MODULE_CONTROL_OFFSET = 12'h040;
	localparam logic [11:0] SELECTED_STATUS_OFFSET = 12'h044;
	localparam logic [11:0] CAPS_OFFSET = 12'h048;
	localparam int ACTIVE_BIT = 0;
	localparam int PLATFORM_RESET_BIT = 1;
	localparam int CLR_RESET_HALT_BIT = 2;
	localparam int SET_RESET_HALT_BIT = 3;
	localparam int CLR_KEEP_ALIVE_BIT = 4;
	localparam int SET_KEEP_ALIVE_BIT = 5;
	localparam int HART_SEL_HI_LSB = 6;
	localparam int HART_SEL_LO_LSB = 16;
	localparam int HART_SEL_FIELD_W = 10;
	localparam int MULTI_SEL_BIT = 26;
	localparam int ACK_UNAVAIL_BIT = 27;
	localparam int ACK_RESET_BIT = 28;
	localparam int HART_RESET_BIT = 29;
	localparam int RESUME_BIT = 30;
	localparam int HALT_REQ_BIT = 31;
	localparam int MAX_INDEX_W = 20;
	localparam logic [3:0] VERSION_VALUE = 4'h3;
	localparam int ACTIVATE_DELAY_CYCLES = 2;
endpackage : module_control_pkg

// [verification/hart_cluster_model.sv]
// behavioural harts driven by the control register outputs
`timescale 1ns/1ps
module hart_cluster_model #(
	parameter int N = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [N-1:0] halt_req_r,
	input wire logic [N-1:0] resume_pulse_r,
	input wire logic [N-1:0] hart_reset_r,
	input wire logic [N-1:0] reset_halt_req_r,
	input wire logic [N-1:0] keep_alive_r,
	input wire logic platform_reset_r,
	input wire logic [N-1:0] sleep_req,
	output logic [N-1:0] hart_halted,
	output logic [N-1:0] hart_available,
	output logic [N-1:0] hart_resume_done,
	output logic [N-1:0] hart_was_reset,
	output logic [N-1:0] hart_went_unavail
);
	// ---
	// hart behaviour
	// ---
	logic [N-1:0] in_rst, in_rst_r;
	assign in_rst = hart_reset_r | {N{platform_reset_r}};
	// keep-alive always wins here; real harts may still drop out
	assign hart_available = ~sleep_req | keep_alive_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_rst_r <= '0;
			hart_halted <= '0;
			hart_resume_done <= '0;
			hart_was_reset <= '0;
			hart_went_unavail <= '0;
		end else begin
			in_rst_r <= in_rst;
			hart_halted <= ((hart_halted & ~resume_pulse_r) | halt_req_r
				| (in_rst_r & ~in_rst & reset_halt_req_r)) & ~in_rst;
			hart_resume_done <= resume_pulse_r & hart_halted;
			hart_was_reset <= in_rst_r & ~in_rst;
			hart_went_unavail <= ~hart_available;
		end
	end
endmodule : hart_cluster_model

// [verification/module_control_checker.sv]
// port assertions for the control register block
`timescale 1ns/1ps
module module_control_checker import module_control_pkg::*; #(
	parameter int NUM_HARTS = 4,
	parameter int INDEX_W = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic [NUM_HARTS-1:0] halt_req_r,
	input wire logic [NUM_HARTS-1:0] resume_pulse_r,
	input wire logic [NUM_HARTS-1:0] hart_reset_r,
	input wire logic [NUM_HARTS-1:0] keep_alive_r,
	input wire logic platform_reset_r,
	input wire logic active_r
);
	// ---
	// properties
	// ---
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, wr, one;
	logic [INDEX_W-1:0] idx;
	assign acc = psel && penable && pready && paddr == MODULE_CONTROL_OFFSET;
	assign wr = acc && pwrite && active_r && pwdata[ACTIVE_BIT];
	// single-hart writes only; mask mode is judged by the bench
	assign one = wr && !pwdata[MULTI_SEL_BIT];
	assign idx = pwdata[HART_SEL_LO_LSB +: INDEX_W];
	halt_follow_a: assert property (one |=> halt_req_r[$past(idx)] == $past(pwdata[31]))
		else $error("halt request mismatch");
	hart_reset_a: assert property (one |=> hart_reset_r[$past(idx)] == $past(pwdata[29]))
		else $error("hart reset mismatch");
	keep_clear_a: assert property (one && pwdata[4] |=> !keep_alive_r[$past(idx)])
		else $error("keep-alive clear lost");
	resume_block_a: assert property (wr && pwdata[31] && pwdata[30] |=> (resume_pulse_r == '0)[*3])
		else $error("resume not ignored");
	pulse_once_a: assert property (|resume_pulse_r |=> resume_pulse_r == '0)
		else $error("resume pulse too long");
	plat_reset_a: assert property (wr |=> platform_reset_r == $past(pwdata[1]))
		else $error("platform reset mismatch");
	idle_state_a: assert property (!active_r && !$past(active_r) |-> {halt_req_r, hart_reset_r, keep_alive_r, platform_reset_r} == '0)
		else $error("state kept while inactive");
	wake_time_a: assert property (acc && pwrite && pwdata[0] && !active_r |-> ##[1:4] active_r)
		else $error("activation too slow");
	strobe_zero_a: assert property (acc && !pwrite |-> (prdata & 32'hD800003C) == '0)
		else $error("strobe reads nonzero");
endmodule : module_control_checker

// [verification/module_control_test.sv]
// self-checking bench for the control register block
`timescale 1ns/1ps
module module_control_test import module_control_pkg::*; ();
	// ---
	// stimulus and checks
	// ---
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, perr;
	logic pready, pslverr, platform_reset_r, active_r;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, q, d, p = 32'h0;
	logic [3:0] array_mask = 4'h0, sleep_req = 4'h0, hart_halted, hart_available, hw, s, seen;
	logic [3:0] hart_resume_done, hart_was_reset, hart_went_unavail, hq = 4'h0, hr = 4'h0;
	logic [3:0] halt_req_r, resume_pulse_r, hart_reset_r, reset_halt_req_r, keep_alive_r;
	logic [3:0] ka = 4'h0, rh = 4'h0;
	int miscompares = 0, cmp_count = 0, seed = 32'h543f, k;
	int strobes[5] = '{RESUME_BIT, HART_RESET_BIT, ACK_RESET_BIT, SET_RESET_HALT_BIT,
		CLR_RESET_HALT_BIT};
	always #5 pclk = ~pclk;
	module_control module_control_i (.*);
	hart_cluster_model hart_cluster_model_i (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		// no wait-state limit here, only the watchdog ends a hung access
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		perr = pslverr;
		hw = hart_halted;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : xfer
	function automatic logic [3:0] selected_harts(input logic [31:0] v);
		return (4'h1 << v[HART_SEL_LO_LSB +: 2]) | (v[MULTI_SEL_BIT] ? array_mask : 4'h0);
	endfunction : selected_harts
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h8000_0002);
		xfer(1'h0, MODULE_CONTROL_OFFSET, 32'h0);
		chk(q | {24'h0, halt_req_r, 3'h0, platform_reset_r}, 32'h0);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h1);
		k = 0;
		do xfer(1'h0, MODULE_CONTROL_OFFSET, 32'h0); while (q[ACTIVE_BIT] !== 1'h1 && ++k < 9);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h07FF_FFC1);
		xfer(1'h0, MODULE_CONTROL_OFFSET, 32'h0);
		chk(q, 32'h0403_0001);
		xfer(1'h0, 12'h0FC, 32'h0);
		chk({perr, q[30:0]}, 32'h8000_0000);
		for (int i = 0; i < 60; i++) begin
			d = $random(seed) & 32'h8FFF_FFF0;
			d[ACTIVE_BIT] = 1'h1;
			d[PLATFORM_RESET_BIT] = (i % 16 == 7);
			k = $unsigned($random(seed)) % 7;
			if (k < 5 && i < 59) d[strobes[k]] = 1'h1;
			// random commands run here; index writes are free only while no hart is in reset
			// selection frozen while any hart sits in reset
			if (hr != 4'h0) d[26:6] = p[26:6];
			if (hr == 4'h0) array_mask <= 4'($random(seed));
			sleep_req <= 4'($random(seed));
			xfer(1'h1, MODULE_CONTROL_OFFSET, d);
			p = d;
			s = selected_harts(d);
			hq = d[HALT_REQ_BIT] ? hq | s : hq & ~s;
			hr = d[HART_RESET_BIT] ? hr | s : hr & ~s;
			if (d[CLR_KEEP_ALIVE_BIT]) ka = ka & ~s;
			else if (d[SET_KEEP_ALIVE_BIT]) ka = ka | s;
			if (d[CLR_RESET_HALT_BIT]) rh = rh & ~s;
			else if (d[SET_RESET_HALT_BIT]) rh = rh | s;
			seen = resume_pulse_r;
			repeat (2) begin
				@(posedge pclk);
				seen = seen | resume_pulse_r;
			end
			chk({28'h0, seen}, {28'h0, (d[30] && !d[31]) ? s & hw : 4'h0});
			chk({halt_req_r, hart_reset_r, keep_alive_r, reset_halt_req_r, 15'h0, platform_reset_r},
				{hq, hr, ka, rh, 15'h0, d[PLATFORM_RESET_BIT]});
			xfer(1'h0, MODULE_CONTROL_OFFSET, 32'h0);
			chk(q, {2'h0, |(hr & s), 2'h0, d[26], 8'h0, d[17:16], 14'h0, d[1:0]});
		end
		// directed status corners on hart 0
		sleep_req <= 4'h0;
		xfer(1'h1, MODULE_CONTROL_OFFSET, (p & 32'h07FF_FFC0) | 32'h1);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h0000_0015);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h8000_0001);
		repeat (3) @(posedge pclk);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h4000_0001);
		repeat (3) @(posedge pclk);
		xfer(1'h0, SELECTED_STATUS_OFFSET, 32'h0);
		chk(q & 32'h3F, {26'h0, 2'h3, VERSION_VALUE});
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h2000_0001);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		xfer(1'h0, SELECTED_STATUS_OFFSET, 32'h0);
		chk(q & 32'h40, 32'h40);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h1000_0001);
		repeat (3) @(posedge pclk);
		xfer(1'h0, SELECTED_STATUS_OFFSET, 32'h0);
		chk(q & 32'h40, 32'h0);
		sleep_req <= 4'h1;
		repeat (3) @(posedge pclk);
		xfer(1'h0, SELECTED_STATUS_OFFSET, 32'h0);
		chk(q & 32'h80, 32'h80);
		sleep_req <= 4'h0;
		repeat (2) @(posedge pclk);
		xfer(1'h1, MODULE_CONTROL_OFFSET, 32'h0800_0001);
		repeat (3) @(posedge pclk);
		xfer(1'h0, SELECTED_STATUS_OFFSET, 32'h0);
		chk(q & 32'h80, 32'h0);
		chk({28'h0, q[3:0]}, {28'h0, VERSION_VALUE});
		complete_run();
	end
	initial begin
		#100us;
		miscompares++;
		complete_run();
	end
endmodule : module_control_test
bind module_control module_control_checker #(.NUM_HARTS(NUM_HARTS), .INDEX_W(INDEX_W))
	module_control_checker_i (.*);
